// ---- hdl/shift_storage_top.sv ----
// eight-bit universal shift and storage register with shared parallel
// terminals, serial cascade outputs, a capture buffer and an AXI4-Lite slave.
// assumes all device pins are asynchronous to CLOCK_I and that the bench
// resolves the shared terminals from IO_BITS_O and IO_BITS_OE_O.
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "shift_storage_cfg.svh"
// first-in first-out buffer in flip-flops, valid and ready on both sides
module capture_fifo
    import shift_storage_pkg::*;
#(
    parameter int WIDTH = `REG_BITS,
    parameter int DEPTH = `FIFO_DEPTH_DEFAULT
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH):0] level_o
);
    localparam int PTR_BITS = $clog2(DEPTH);
    // pointers do not wrap cleanly unless the depth is a power of two
    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("capture_fifo depth must be a power of two of at least 2");
        end
    endgenerate
    logic [WIDTH-1:0] store [DEPTH];  // storage words
    logic [PTR_BITS:0] wr_ptr;  // write pointer with wrap bit
    logic [PTR_BITS:0] rd_ptr;  // read pointer with wrap bit
    logic push;  // word accepted on the filling side
    logic pop;  // word taken on the draining side
    assign level_o = wr_ptr - rd_ptr;
    assign in_ready_o = (level_o != DEPTH[PTR_BITS:0] << 0) && !level_o[PTR_BITS];
    assign out_valid_o = (wr_ptr != rd_ptr);
    assign out_data_o = store[rd_ptr[PTR_BITS-1:0]];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    // storage is written only, never reset, to keep it plain flip-flops
    always_ff @(posedge clk_i) begin
        if (push) begin
            store[wr_ptr[PTR_BITS-1:0]] <= in_data_i;
        end
    end
    // write pointer
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
        end else if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end
    // read pointer
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_ptr <= '0;
        end else if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule : capture_fifo
// the register itself and its bus slave
module shift_storage_top
    import shift_storage_pkg::*;
#(
    parameter int FIFO_DEPTH = `FIFO_DEPTH_DEFAULT
) (
    input wire logic CLOCK_I,
    input wire logic RSTN_I,
    // device pins
    input wire logic SYNC_CLEAR_N_I,
    input wire logic FUNC_SELECT_LOW_I,
    input wire logic FUNC_SELECT_HIGH_I,
    input wire logic OUT_ENABLE_N_FIRST_I,
    input wire logic OUT_ENABLE_N_SECOND_I,
    input wire logic RIGHT_SERIAL_IN_I,
    input wire logic LEFT_SERIAL_IN_I,
    input wire logic [`REG_BITS-1:0] IO_BITS_I,
    output logic [`REG_BITS-1:0] IO_BITS_O,
    output logic [`REG_BITS-1:0] IO_BITS_OE_O,
    output logic FIRST_STAGE_SERIAL_OUT_O,
    output logic LAST_STAGE_SERIAL_OUT_O,
    output logic CAPTURE_READY_O,
    // AXI4-Lite slave
    input wire logic [`AXI_ADDR_BITS-1:0] AWADDR_I,
    input wire logic [2:0] AWPROT_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [`AXI_DATA_BITS-1:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    output logic [1:0] BRESP_O,
    output logic BVALID_O,
    input wire logic BREADY_I,
    input wire logic [`AXI_ADDR_BITS-1:0] ARADDR_I,
    input wire logic [2:0] ARPROT_I,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    output logic [`AXI_DATA_BITS-1:0] RDATA_O,
    output logic [1:0] RRESP_O,
    output logic RVALID_O,
    input wire logic RREADY_I
);
    localparam int LVL_BITS = $clog2(FIFO_DEPTH) + 1;
    // status field layout needs the level to fit above its lsb
    generate
        if (LVL_BITS > `AXI_DATA_BITS - `STAT_LEVEL_LSB) begin : g_bad_level
            $error("capture buffer too deep for the status level field");
        end
    endgenerate
    // word-aligned address decode, shared by the read and write paths
    function automatic reg_sel_type decode_addr(input logic [`AXI_ADDR_BITS-1:0] addr);
        case ({addr[`AXI_ADDR_BITS-1:2], 2'h0})
            `OFF_CTRL: decode_addr = SEL_CTRL;
            `OFF_STATUS: decode_addr = SEL_STATUS;
            `OFF_CAPTURE: decode_addr = SEL_CAPTURE;
            default: decode_addr = SEL_NONE;
        endcase
    endfunction : decode_addr
    pin_in_type pins_raw;  // pins as they arrive
    pin_in_type pins_meta;  // first synchroniser stage, read only below
    pin_in_type pins;  // synchronised pins, safe for logic
    mode_type mode;  // mode from the synchronised selects
    logic [`REG_BITS-1:0] bits;  // the storage register, bit 0 is stage A
    logic [`REG_BITS-1:0] next_bits;  // value taken at the next edge
    logic update;  // the next edge changes the register by mode or clear
    logic drive_en;  // device drives the shared terminals
    logic [1:0] float_age;  // cycles the terminals have floated, saturating
    logic load_ok;  // sampled terminal levels postdate the float
    logic capture_en;  // software enables pushing updates into the buffer
    logic overflow;  // sticky: an update found the buffer full
    logic fifo_valid;  // buffer has a word
    logic fifo_pop;  // buffer word taken by a read
    logic [`REG_BITS-1:0] fifo_data;  // oldest buffered word
    logic [LVL_BITS-1:0] fifo_level;  // words held
    logic push;  // update offered to the buffer
    logic aw_held;  // write address latched
    logic [`AXI_ADDR_BITS-1:0] aw_addr;  // latched write address
    logic w_held;  // write data latched
    logic [`AXI_DATA_BITS-1:0] w_data;  // latched write data
    logic [3:0] w_strb;  // latched byte strobes
    logic wr_go;  // both halves present and response channel free
    reg_sel_type wr_sel;  // register hit by the write
    reg_sel_type rd_sel;  // register hit by the read
    logic ar_fire;  // read address taken
    logic clear_overflow;  // write of one to the overflow bit
    assign pins_raw = '{
        sync_clear_n: SYNC_CLEAR_N_I,
        func_select_high: FUNC_SELECT_HIGH_I,
        func_select_low: FUNC_SELECT_LOW_I,
        out_enable_n_first: OUT_ENABLE_N_FIRST_I,
        out_enable_n_second: OUT_ENABLE_N_SECOND_I,
        right_serial_in: RIGHT_SERIAL_IN_I,
        left_serial_in: LEFT_SERIAL_IN_I,
        io_bits: IO_BITS_I
    };
    // two-flop synchroniser on every pin; all pins share the same latency
    // so a select and its data stay aligned
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pins_meta <= '{sync_clear_n: 1'b1, out_enable_n_first: 1'b1,
                           out_enable_n_second: 1'b1, default: '0};
            pins <= '{sync_clear_n: 1'b1, out_enable_n_first: 1'b1,
                      out_enable_n_second: 1'b1, default: '0};
        end else begin
            pins_meta <= pins_raw;
            pins <= pins_meta;
        end
    end
    assign mode = mode_type'({pins.func_select_high, pins.func_select_low});
    // terminals float in load mode or with either enable high
    assign drive_en = !pins.out_enable_n_first && !pins.out_enable_n_second
        && (mode != MODE_LOAD);
    assign IO_BITS_OE_O = {`REG_BITS{drive_en}};
    assign IO_BITS_O = bits;
    // the sampled levels lag the pins by two cycles, so a load waits until
    // the terminals have floated that long; otherwise it would catch our
    // own driven value instead of the outside party's
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            float_age <= 2'h0;
        end else if (drive_en) begin
            float_age <= 2'h0;
        end else if (float_age != `FLOAT_SETTLE) begin
            float_age <= float_age + 2'h1;
        end
    end
    assign load_ok = (float_age == `FLOAT_SETTLE);
    // next register value: clear first, then the selected mode
    always_comb begin
        next_bits = bits;
        update = 1'b0;
        if (!pins.sync_clear_n) begin
            next_bits = '0;
            update = 1'b1;
        end else begin
            case (mode)
                MODE_HOLD: next_bits = bits;
                MODE_SHIFT_RIGHT: begin
                    next_bits = {bits[`REG_BITS-2:0], pins.right_serial_in};
                    update = 1'b1;
                end
                MODE_SHIFT_LEFT: begin
                    next_bits = {pins.left_serial_in, bits[`REG_BITS-1:1]};
                    update = 1'b1;
                end
                MODE_LOAD: begin
                    // until the float has settled the load simply holds
                    if (load_ok) begin
                        next_bits = pins.io_bits;
                        update = 1'b1;
                    end
                end
                default: next_bits = bits;
            endcase
        end
    end
    // the storage register; the enables reach it only through load_ok, which sets once the terminals have floated for two cycles
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            bits <= '0;
        end else begin
            bits <= next_bits;
        end
    end
    // cascade outputs come straight from the end stages
    assign FIRST_STAGE_SERIAL_OUT_O = bits[0];
    assign LAST_STAGE_SERIAL_OUT_O = bits[`REG_BITS-1];
    // every changing edge offers its new value to the buffer; a full buffer
    // does not stall the register, whose pins cannot be held off, so the
    // word is lost and flagged
    assign push = capture_en && update;
    capture_fifo #(
        .WIDTH(`REG_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_capture_fifo (
        .clk_i(CLOCK_I),
        .rst_n_i(RSTN_I),
        .in_valid_i(push),
        .in_ready_o(CAPTURE_READY_O),
        .in_data_i(next_bits),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_data),
        .level_o(fifo_level)
    );
    // write channel acceptance: each half latched on its own handshake
    assign AWREADY_O = !aw_held && !BVALID_O;
    assign WREADY_O = !w_held && !BVALID_O;
    assign wr_go = aw_held && w_held && !BVALID_O;
    assign wr_sel = decode_addr(aw_addr);
    // latch write address
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (AWVALID_I && AWREADY_O) begin
            aw_held <= 1'b1;
            aw_addr <= AWADDR_I;
        end else if (wr_go) begin
            aw_held <= 1'b0;
        end
    end
    // latch write data and strobes
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (WVALID_I && WREADY_O) begin
            w_held <= 1'b1;
            w_data <= WDATA_I;
            w_strb <= WSTRB_I;
        end else if (wr_go) begin
            w_held <= 1'b0;
        end
    end
    // write response; unmapped addresses answer with an error
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            BVALID_O <= 1'b0;
            BRESP_O <= `RESP_OKAY;
        end else if (wr_go) begin
            BVALID_O <= 1'b1;
            BRESP_O <= (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        end else if (BREADY_I) begin
            BVALID_O <= 1'b0;
        end
    end
    // control register: capture enable, byte lane 0
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            capture_en <= `CTRL_RESET;
        end else if (wr_go && wr_sel == SEL_CTRL && w_strb[0]) begin
            capture_en <= w_data[`CTRL_CAPTURE_EN_BIT];
        end
    end
    assign clear_overflow = wr_go && (wr_sel == SEL_STATUS) && w_strb[1]
        && w_data[`STAT_OVERFLOW_BIT];
    // overflow flag: a lost word in the clearing cycle still sets it
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            overflow <= 1'b0;
        end else if (push && !CAPTURE_READY_O) begin
            overflow <= 1'b1;
        end else if (clear_overflow) begin
            overflow <= 1'b0;
        end
    end
    // read channel: one read at a time, answered the cycle after
    assign ARREADY_O = !RVALID_O;
    assign ar_fire = ARVALID_I && ARREADY_O;
    assign rd_sel = decode_addr(ARADDR_I);
    assign fifo_pop = ar_fire && (rd_sel == SEL_CAPTURE);
    // read data and response
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            RVALID_O <= 1'b0;
            RDATA_O <= '0;
            RRESP_O <= `RESP_OKAY;
        end else if (ar_fire) begin
            RVALID_O <= 1'b1;
            RRESP_O <= `RESP_OKAY;
            RDATA_O <= '0;
            case (rd_sel)
                SEL_CTRL: begin
                    RDATA_O[`CTRL_CAPTURE_EN_BIT] <= capture_en;
                end
                SEL_STATUS: begin
                    RDATA_O[`STAT_BITS_LSB +: `REG_BITS] <= bits;
                    RDATA_O[`STAT_EMPTY_BIT] <= !fifo_valid;
                    RDATA_O[`STAT_FULL_BIT] <= !CAPTURE_READY_O;
                    RDATA_O[`STAT_OVERFLOW_BIT] <= overflow;
                    RDATA_O[`STAT_LEVEL_LSB +: LVL_BITS] <= fifo_level;
                end
                SEL_CAPTURE: begin
                    // an empty buffer reads as zero with the valid bit low
                    RDATA_O[`REG_BITS-1:0] <= fifo_valid ? fifo_data : '0;
                    RDATA_O[`CAPTURE_VALID_BIT] <= fifo_valid;
                end
                default: begin
                    RRESP_O <= `RESP_SLVERR;
                end
            endcase
        end else if (RREADY_I) begin
            RVALID_O <= 1'b0;
        end
    end
endmodule : shift_storage_top

// ---- hdl/shift_storage_cfg.svh ----
// constants of the eight-bit universal shift and storage register:
// register offsets, field positions, reset values and buffer sizes.
// assumes it is included by bare name from the package and the design.
`ifndef SHIFT_STORAGE_CFG_SVH
`define SHIFT_STORAGE_CFG_SVH

// width of the storage register and default depth of the capture buffer
`define REG_BITS 8
`define FIFO_DEPTH_DEFAULT 16

// register bus geometry
`define AXI_ADDR_BITS 8
`define AXI_DATA_BITS 32

// register byte offsets
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_CAPTURE 8'h08

// control register fields and reset value
`define CTRL_CAPTURE_EN_BIT 0
`define CTRL_RESET 1'b0

// status register fields
`define STAT_BITS_LSB 0
`define STAT_EMPTY_BIT 8
`define STAT_FULL_BIT 9
`define STAT_OVERFLOW_BIT 10
`define STAT_LEVEL_LSB 16

// capture register fields
`define CAPTURE_VALID_BIT 8

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// cycles the terminals must float before a load sample is trusted
`define FLOAT_SETTLE 2'h2

`endif

// ---- hdl/shift_storage_pkg.sv ----
// types shared by the shift and storage register design.
// assumes shift_storage_cfg.svh is on the include path.
`include "shift_storage_cfg.svh"

package shift_storage_pkg;

    // operating mode, coded as {func_select_high, func_select_low};
    // hold, right, load, left is a gray walk
    typedef enum logic [1:0] {
        MODE_HOLD = 2'h0,
        MODE_SHIFT_RIGHT = 2'h1,
        MODE_LOAD = 2'h3,
        MODE_SHIFT_LEFT = 2'h2
    } mode_type;

    // register selected by a bus address
    typedef enum logic [1:0] {
        SEL_CTRL = 2'h0,
        SEL_STATUS = 2'h1,
        SEL_CAPTURE = 2'h3,
        SEL_NONE = 2'h2
    } reg_sel_type;

    // pin levels that travel together through the synchroniser
    typedef struct packed {
        logic sync_clear_n;
        logic func_select_high;
        logic func_select_low;
        logic out_enable_n_first;
        logic out_enable_n_second;
        logic right_serial_in;
        logic left_serial_in;
        logic [`REG_BITS-1:0] io_bits;
    } pin_in_type;

endpackage : shift_storage_pkg

// ---- verif/shift_storage_chk.sv ----
// checker for the shift and storage register: pin timing and read channel.
// assumes every pin passes a two-stage synchroniser before it acts.
`timescale 1ns/1ps
`include "shift_storage_cfg.svh"
module shift_storage_chk (
    input wire logic CLOCK_I,
    input wire logic RSTN_I,
    input wire logic SYNC_CLEAR_N_I,
    input wire logic FUNC_SELECT_LOW_I,
    input wire logic FUNC_SELECT_HIGH_I,
    input wire logic OUT_ENABLE_N_FIRST_I,
    input wire logic OUT_ENABLE_N_SECOND_I,
    input wire logic RIGHT_SERIAL_IN_I,
    input wire logic LEFT_SERIAL_IN_I,
    input wire logic [`REG_BITS-1:0] IO_BITS_O,
    input wire logic [`REG_BITS-1:0] IO_BITS_OE_O,
    input wire logic FIRST_STAGE_SERIAL_OUT_O,
    input wire logic LAST_STAGE_SERIAL_OUT_O,
    input wire logic ARVALID_I,
    input wire logic ARREADY_O,
    input wire logic RVALID_O,
    input wire logic RREADY_I
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RSTN_I);
    // load or any enable high floats all terminals two edges later
    property p_float;
        (FUNC_SELECT_HIGH_I && FUNC_SELECT_LOW_I) || OUT_ENABLE_N_FIRST_I
            || OUT_ENABLE_N_SECOND_I |-> ##2 IO_BITS_OE_O == 8'h00;
    endproperty
    a_float: assert property (p_float)
        else $error("terminals driven while they should float");
    // enabled and not loading: every terminal driven
    property p_drive;
        !(FUNC_SELECT_HIGH_I && FUNC_SELECT_LOW_I) && !OUT_ENABLE_N_FIRST_I
            && !OUT_ENABLE_N_SECOND_I |-> ##2 IO_BITS_OE_O == 8'hFF;
    endproperty
    a_drive: assert property (p_drive)
        else $error("terminals not driven");
    // clear acts on the third edge, whatever the mode
    property p_clear;
        !SYNC_CLEAR_N_I |-> ##3 IO_BITS_O == 8'h00;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not zero the register");
    property p_hold;
        SYNC_CLEAR_N_I && !FUNC_SELECT_HIGH_I && !FUNC_SELECT_LOW_I
            |-> ##3 IO_BITS_O == $past(IO_BITS_O);
    endproperty
    a_hold: assert property (p_hold)
        else $error("hold changed the register");
    property p_right;
        SYNC_CLEAR_N_I && !FUNC_SELECT_HIGH_I && FUNC_SELECT_LOW_I
            |-> ##3 IO_BITS_O == {$past(IO_BITS_O[6:0]), $past(RIGHT_SERIAL_IN_I, 3)};
    endproperty
    a_right: assert property (p_right)
        else $error("wrong shift right");
    property p_left;
        SYNC_CLEAR_N_I && FUNC_SELECT_HIGH_I && !FUNC_SELECT_LOW_I
            |-> ##3 IO_BITS_O == {$past(LEFT_SERIAL_IN_I, 3), $past(IO_BITS_O[7:1])};
    endproperty
    a_left: assert property (p_left)
        else $error("wrong shift left");
    // cascade outputs always mirror the end stages
    property p_serial;
        FIRST_STAGE_SERIAL_OUT_O == IO_BITS_O[0] && LAST_STAGE_SERIAL_OUT_O == IO_BITS_O[7];
    endproperty
    a_serial: assert property (p_serial)
        else $error("serial outputs differ from end stages");
    property p_rtake;
        ARVALID_I && ARREADY_O |=> RVALID_O && !ARREADY_O;
    endproperty
    a_rtake: assert property (p_rtake)
        else $error("read not answered on the next edge");
    property p_rdone;
        RVALID_O && RREADY_I |=> !RVALID_O;
    endproperty
    a_rdone: assert property (p_rdone)
        else $error("read data kept after acceptance");
endmodule : shift_storage_chk

bind shift_storage_top shift_storage_chk u_chk (.*);

// ---- verif/terminal_driver_model.sv ----
// far-side logic that drives the shared terminals during loads.
// assumes per-bit device enables; it never drives a bit the device drives.
`timescale 1ns/1ps
module terminal_driver_model (
    input wire logic clk_i,
    input wire logic drive_en_i,
    input wire logic [7:0] drive_val_i,
    input wire logic [7:0] dev_out_i,
    input wire logic [7:0] dev_oe_i,
    output logic [7:0] wire_o
);
    logic [7:0] stale = 8'h00; // level of a line nobody drives
    // a released line flips each cycle so no old value can pass for data
    always @(posedge clk_i) begin
        stale <= ~wire_o;
    end
    // drive only floated bits and only while a load is asked for
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (dev_oe_i[i]) begin
                wire_o[i] = dev_out_i[i];
            end else if (drive_en_i) begin
                wire_o[i] = drive_val_i[i];
            end else begin
                wire_o[i] = stale[i];
            end
        end
    end
endmodule : terminal_driver_model

// ---- verif/universal_shift_storage_register_test.sv ----
// self-checking bench: register bus, capture buffer, pins and load.
// assumes the partner model resolves the shared terminals.
`timescale 1ns/1ps
`include "shift_storage_cfg.svh"
module universal_shift_storage_register_test import shift_storage_pkg::*;;
    logic clk = 1'b0, rst_n, clear_n, sel_hi, sel_lo, en_n1, en_n2, rsin, lsin, drive_en;
    logic so_a, so_h, cap_rdy, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
    logic [7:0] drive_val, io_in, io_out, io_oe, awaddr, araddr;
    logic [31:0] wdata, rdata, seed;
    logic [1:0] bresp, rresp;
    logic [33:0] rq[$]; // expected read answers, oldest first
    logic [1:0] wq[$]; // expected write answers
    int n_fail = 0;
    int check_count = 0;
    always #12.5 clk = ~clk;
    shift_storage_top dut (.CLOCK_I(clk), .RSTN_I(rst_n), .SYNC_CLEAR_N_I(clear_n),
        .FUNC_SELECT_LOW_I(sel_lo), .FUNC_SELECT_HIGH_I(sel_hi), .OUT_ENABLE_N_FIRST_I(en_n1),
        .OUT_ENABLE_N_SECOND_I(en_n2), .RIGHT_SERIAL_IN_I(rsin), .LEFT_SERIAL_IN_I(lsin),
        .IO_BITS_I(io_in), .IO_BITS_O(io_out), .IO_BITS_OE_O(io_oe),
        .FIRST_STAGE_SERIAL_OUT_O(so_a), .LAST_STAGE_SERIAL_OUT_O(so_h), .CAPTURE_READY_O(cap_rdy),
        .AWADDR_I(awaddr), .AWPROT_I(3'h0), .AWVALID_I(awvalid), .AWREADY_O(awready),
        .WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
        .BVALID_O(bvalid), .BREADY_I(1'b1), .ARADDR_I(araddr), .ARPROT_I(3'h0),
        .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp),
        .RVALID_O(rvalid), .RREADY_I(1'b1));
    terminal_driver_model partner (.clk_i(clk), .drive_en_i(drive_en), .drive_val_i(drive_val),
        .dev_out_i(io_out), .dev_oe_i(io_oe), .wire_o(io_in));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    // write: offer address and data together, drop each once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        n = 0;
        wq.push_back(e);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        if (n >= 50) n_fail++;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        int n;
        n = 0;
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        if (n >= 50) n_fail++;
    endtask : rd
    // pins are levels: mode {high,low}, clear, serial inputs, held n edges
    task automatic pins(input logic [1:0] md, input logic c, input logic l, input logic r,
        input int n);
        {sel_hi, sel_lo} <= md;
        clear_n <= c;
        lsin <= l;
        rsin <= r;
        repeat (n) @(posedge clk);
    endtask : pins
    // answers are compared in order as they appear on the bus
    always @(posedge clk) begin
        if (rvalid === 1'b1 && rq.size() > 0) check("read", {rresp, rdata}, rq.pop_front());
        if (bvalid === 1'b1 && wq.size() > 0) check("bresp", 34'(bresp), 34'(wq.pop_front()));
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        final_report();
    end
    initial begin
        {rst_n, sel_hi, sel_lo, en_n1, en_n2, rsin, lsin, drive_en, awvalid, wvalid, arvalid} = '0;
        {clear_n, drive_val, awaddr, araddr, wdata, seed} = {1'b1, 56'h0, 32'd92284};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd(`OFF_CTRL, {`RESP_OKAY, 32'h0});
        rd(`OFF_CAPTURE + 8'h04, {`RESP_SLVERR, 32'h0});
        wr(`OFF_CAPTURE + 8'h04, 32'h1, `RESP_SLVERR);
        wr(`OFF_CTRL, 32'h1, `RESP_OKAY);
        rd(`OFF_CTRL, {`RESP_OKAY, 32'h1});
        $display("test registers done");
        // 17 changes into a 16-word buffer: the last is dropped
        pins(2'b10, 1'b1, 1'b1, 1'b0, 8);
        pins(2'b01, 1'b1, 1'b0, 1'b0, 8);
        pins(2'b01, 1'b1, 1'b0, 1'b1, 1);
        pins(2'b00, 1'b1, 1'b0, 1'b0, 4);
        check("buffer_ready", 34'(cap_rdy), 34'h0);
        rd(`OFF_STATUS, {`RESP_OKAY, 32'h00100601});
        for (int i = 0; i < 16; i++) begin
            rd(`OFF_CAPTURE, {`RESP_OKAY, 23'h0, 1'b1, i < 8 ? 8'hFF << (7 - i) : 8'hFF << (i - 7)});
        end
        rd(`OFF_CAPTURE, {`RESP_OKAY, 32'h0});
        rd(`OFF_STATUS, {`RESP_OKAY, 32'h00000501});
        wr(`OFF_STATUS, 32'h400, `RESP_OKAY);
        rd(`OFF_STATUS, {`RESP_OKAY, 32'h00000101});
        wr(`OFF_CTRL, 32'h0, `RESP_OKAY);
        $display("test buffer done");
        // random modes, enables and clears; the checker judges each edge
        for (int i = 0; i < 400; i++) begin
            seed = lfsr(seed);
            en_n1 <= seed[5];
            en_n2 <= seed[6] & seed[7];
            pins(seed[1:0] == 2'b11 ? 2'b00 : seed[1:0], |seed[4:2], seed[8], seed[9], 1);
        end
        $display("test random done");
        {en_n1, en_n2} <= 2'b00;
        drive_val <= 8'hA5;
        drive_en <= 1'b1;
        pins(2'b11, 1'b1, 1'b0, 1'b0, 8);
        check("load_bits", 34'(io_out), 34'hA5);
        check("load_oe", 34'(io_oe), 34'h0);
        pins(2'b11, 1'b0, 1'b0, 1'b0, 4);
        check("clear_bits", 34'(io_out), 34'h0);
        check("clear_oe", 34'(io_oe), 34'h0);
        drive_en <= 1'b0;
        pins(2'b00, 1'b1, 1'b0, 1'b0, 4);
        check("hold_oe", 34'(io_oe), 34'hFF);
        $display("test load done");
        en_n1 <= 1'b1;
        pins(2'b01, 1'b1, 1'b0, 1'b1, 3);
        pins(2'b00, 1'b1, 1'b0, 1'b0, 4);
        check("float_bits", 34'(io_out), 34'h07);
        check("float_oe", 34'(io_oe), 34'h0);
        check("serial", 34'({so_h, so_a}), 34'h1);
        {en_n1, en_n2} <= 2'b01;
        pins(2'b00, 1'b1, 1'b0, 1'b0, 4);
        check("second_oe", 34'(io_oe), 34'h0);
        en_n2 <= 1'b0;
        pins(2'b00, 1'b1, 1'b0, 1'b0, 4);
        check("drive_oe", 34'(io_oe), 34'hFF);
        check("held_bits", 34'(io_out), 34'h07);
        $display("test enables done");
        final_report();
    end
endmodule : universal_shift_storage_register_test
